// file: rtl/bcc_defs.svh
// constants of the bcd clock calendar core
`ifndef BCC_DEFS_SVH
`define BCC_DEFS_SVH
// ============================================================
// clocks and time base
`define BCC_CLK_HZ         20000000
`define BCC_TB_HZ          32768
`define BCC_ACC_W          25
// half-minute adjust: least hold time 31.25 ms, in units of 10 us
`define BCC_ADJ_TIME_10US  3125
`define BCC_ADJ_TB         ((`BCC_ADJ_TIME_10US * `BCC_TB_HZ + 99999) / 100000)
// reference pulse width 122.1 us, in ns, as time base ticks
`define BCC_REF_PULSE_NS   122100
`define BCC_REF_TB         ((64'd122100 * 64'd32768 + 64'd500000000) / 64'd1000000000)
// host: hold settling time 150 us, least
`define BCC_HOLD_SETUP_US  150
`define BCC_HOLD_CYC       ((`BCC_HOLD_SETUP_US * (`BCC_CLK_HZ / 1000) + 999) / 1000)
`define BCC_STROBE_CYC     4
// ============================================================
// digit addresses
`define BCC_A_SEC_U        4'h0
`define BCC_A_SEC_T        4'h1
`define BCC_A_MIN_U        4'h2
`define BCC_A_MIN_T        4'h3
`define BCC_A_HR_U         4'h4
`define BCC_A_HR_T         4'h5
`define BCC_A_WDAY         4'h6
`define BCC_A_DAY_U        4'h7
`define BCC_A_DAY_T        4'h8
`define BCC_A_MON_U        4'h9
`define BCC_A_MON_T        4'ha
`define BCC_A_YR_U         4'hb
`define BCC_A_YR_T         4'hc
`define BCC_A_REF          4'hf
`define BCC_NDIG           13
// ============================================================
// flag bit positions
`define BCC_HR_FMT_BIT     3
`define BCC_HR_PM_BIT      2
`define BCC_LEAP_BIT       2
`define BCC_RESET_DIGIT    4'h0
`endif

// file: rtl/bcc_pkg.sv
// types of the bcd clock calendar core
`default_nettype none
package bcc_pkg;
  typedef logic [3:0] bcc_digit_t;
  typedef enum logic [1:0] {BCC_IDLE, BCC_SETUP, BCC_STROBE, BCC_RELEASE} bcc_hstate_t;
endpackage
`default_nettype wire

// file: rtl/bcc_if.sv
// pin bundle between the clock calendar core and its host
`timescale 1ns/10ps
`default_nettype none
interface bcc_if;
  logic       cs;
  logic       hold;
  logic       rd;
  logic       wr;
  logic       adj;
  logic       test;
  logic [3:0] addr;
  logic [3:0] dev_o;
  logic [3:0] dev_oe;
  logic [3:0] host_o;
  logic [3:0] host_oe;
  wire  [3:0] data;
  // pull-ups hold an undriven line high
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_line
    assign data[gi] = host_oe[gi] ? host_o[gi] : (dev_oe[gi] ? dev_o[gi] : 1'b1);
  end
  modport dev  (input cs, hold, rd, wr, adj, test, addr, data, output dev_o, dev_oe);
  modport host (input data, output cs, hold, rd, wr, adj, test, addr, host_o, host_oe);
endinterface
`default_nettype wire

// file: rtl/bcc_host.sv
// host end: drives the pins of the clock calendar core
`timescale 1ns/10ps
`default_nettype none
`include "bcc_defs.svh"
module bcc_host import bcc_pkg::*; #(
  parameter int HOLD_CYC   = `BCC_HOLD_CYC,
  parameter int STROBE_CYC = `BCC_STROBE_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // request
  input  wire logic       req_valid,
  input  wire logic       req_write,
  input  wire logic [3:0] req_addr,
  input  wire logic [3:0] req_wdata,
  output logic            req_ready,
  // answer
  output logic            rsp_valid,
  output logic [3:0]      rsp_rdata,
  // direct controls
  input  wire logic       adj_in,
  input  wire logic       test_in,
  // pins
  bcc_if.host             pins
);
  // ============================================================
  // state
  bcc_hstate_t st_q;
  logic [11:0] cnt_q;
  logic        is_wr_q;
  logic        cs_q, hold_q, rd_q, wr_q, adj_q, test_q, oe_q;
  logic [3:0]  addr_q, wdat_q;
  wire         take = req_valid & req_ready;
  wire         cnt_end = (cnt_q == 12'h000);

  // sequencer: hold, settle, strobe, release; hold stays far under one second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= BCC_IDLE; cnt_q <= 12'h000; is_wr_q <= 1'b0; req_ready <= 1'b0;
      hold_q <= 1'b0; rd_q <= 1'b0; wr_q <= 1'b0; oe_q <= 1'b0;
      addr_q <= 4'h0; wdat_q <= 4'h0; rsp_valid <= 1'b0; rsp_rdata <= 4'h0;
    end else begin
      rsp_valid <= 1'b0;
      case (st_q)
        BCC_IDLE: begin
          req_ready <= ~take;
          if (take) begin
            hold_q  <= 1'b1;
            is_wr_q <= req_write;
            addr_q  <= req_addr;
            wdat_q  <= req_wdata;
            cnt_q   <= 12'(HOLD_CYC - 1);
            st_q    <= BCC_SETUP;
          end
        end
        BCC_SETUP: begin
          cnt_q <= cnt_q - 12'h001;
          if (cnt_end) begin
            rd_q  <= ~is_wr_q;
            wr_q  <= is_wr_q;
            oe_q  <= is_wr_q;
            cnt_q <= 12'(STROBE_CYC - 1);
            st_q  <= BCC_STROBE;
          end
        end
        BCC_STROBE: begin
          cnt_q <= cnt_q - 12'h001;
          if (cnt_end) begin
            rsp_rdata <= is_wr_q ? 4'h0 : pins.data;
            rd_q <= 1'b0; wr_q <= 1'b0; oe_q <= 1'b0;
            st_q <= BCC_RELEASE;
          end
        end
        BCC_RELEASE: begin
          hold_q    <= 1'b0;
          rsp_valid <= 1'b1;
          req_ready <= 1'b1;
          st_q      <= BCC_IDLE;
        end
        default: st_q <= BCC_IDLE;
      endcase
    end
  end

  // chip enable and direct controls, registered onto the pins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_q <= 1'b0; adj_q <= 1'b0; test_q <= 1'b0;
    end else begin
      cs_q <= 1'b1; adj_q <= adj_in; test_q <= test_in;
    end
  end

  assign pins.cs      = cs_q;
  assign pins.hold    = hold_q;
  assign pins.rd      = rd_q;
  assign pins.wr      = wr_q;
  assign pins.adj     = adj_q;
  assign pins.test    = test_q;
  assign pins.addr    = addr_q;
  assign pins.host_o  = wdat_q;
  assign pins.host_oe = {4{oe_q}};
endmodule // bcc_host
`default_nettype wire

// file: rtl/bcc_dev.sv
// device end: bcd clock calendar core with pin interface
//
// Functional notes
// - four-bit address selects thirteen bcd digits
// - writing either seconds digit clears both
// - day tens bit two marks leap year
// - four-bit data bus, line three msb
// - digit driven only while read high
// - digit loaded only while write high
// - chip enable low ignores inputs, releases bus
// - hold blocks the one hertz tick
// - tick during short hold applied afterwards
// - long adjust clears seconds, rounds minutes
// - test pulses advance addressed seconds units, minute tens, day units or year units digit with carry
// - address fifteen read gives reference signals
// - 1024 hz reference ignores hold level
// - fifteen binary stages from 32768 hz base
// - hours tens holds format and pm flags
`timescale 1ns/10ps
`default_nettype none
`include "bcc_defs.svh"
module bcc_dev import bcc_pkg::*; #(
  parameter int CLK_HZ = `BCC_CLK_HZ,
  parameter int TB_HZ  = `BCC_TB_HZ
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // pins
  bcc_if.dev        pins
);
  // ============================================================
  // time base and divider
  localparam int ADJ_TB = `BCC_ADJ_TB;
  localparam int REF_TB = int'(`BCC_REF_TB);
  logic [`BCC_ACC_W-1:0] acc_q;
  logic [14:0]           pre_q;
  logic [10:0]           adj_cnt_q;
  logic                  pend_q, test_q, adj_done_q;
  bcc_digit_t            dig_q [`BCC_NDIG];
  bcc_digit_t            adv   [`BCC_NDIG];
  bcc_digit_t            dig_d [`BCC_NDIG];
  logic [3:0]            dout_q, doe_q;

  wire [`BCC_ACC_W:0] acc_sum = {1'b0, acc_q} + (`BCC_ACC_W+1)'(TB_HZ);
  wire                tb_tick = (acc_sum >= (`BCC_ACC_W+1)'(CLK_HZ));
  wire                sec_tick = tb_tick & (pre_q == 15'h7fff);

  // chip enable gates every control input
  wire cs       = pins.cs;
  wire hold_eff = cs & pins.hold;
  wire rd_eff   = cs & pins.rd;
  wire wr_eff   = cs & pins.wr;
  wire adj_eff  = cs & pins.adj;
  wire test_eff = cs & pins.test;
  wire [3:0] addr = pins.addr;

  // tick held back while hold is up, then released
  wire tick_go  = (sec_tick | pend_q) & ~hold_eff;
  wire pend_d   = (sec_tick | pend_q) & hold_eff;
  wire adj_fire = adj_eff & ~adj_done_q & (adj_cnt_q == 11'(ADJ_TB));
  wire test_rise = test_eff & ~test_q;

  // phase accumulator keeps the average rate exact at any clk from TB_HZ up to 2^25 Hz
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q <= '0; pre_q <= 15'h0000; pend_q <= 1'b0; test_q <= 1'b0;
    end else begin
      acc_q  <= tb_tick ? `BCC_ACC_W'(acc_sum - (`BCC_ACC_W+1)'(CLK_HZ))
                        : acc_sum[`BCC_ACC_W-1:0];
      pre_q  <= adj_fire ? 15'h0000 : (tb_tick ? pre_q + 15'h0001 : pre_q);
      pend_q <= pend_d & ~adj_fire;
      test_q <= test_eff;
    end
  end

  // adjust must stay up for the full time; fires once per press
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      adj_cnt_q <= 11'h000; adj_done_q <= 1'b0;
    end else if (!adj_eff) begin
      adj_cnt_q <= 11'h000; adj_done_q <= 1'b0;
    end else begin
      if (tb_tick && adj_cnt_q != 11'(ADJ_TB)) adj_cnt_q <= adj_cnt_q + 11'h001;
      if (adj_fire) adj_done_q <= 1'b1;
    end
  end

  // ============================================================
  // carry chain
  function automatic logic [4:0] bcc_step(input bcc_digit_t d, input bcc_digit_t lim);
    bcc_step = (d >= lim) ? {1'b1, 4'h0} : {1'b0, d + 4'h1};
  endfunction

  wire tst_su = test_rise & (addr == `BCC_A_SEC_U);
  wire tst_mt = test_rise & (addr == `BCC_A_MIN_T);
  wire tst_dy = test_rise & (addr == `BCC_A_DAY_U);
  wire tst_yu = test_rise & (addr == `BCC_A_YR_U);
  wire adj_min = adj_fire & (dig_q[`BCC_A_SEC_T] >= 4'h3);

  logic c_su, c_st, c_mu, c_mt, c_hr, c_dy, c_mo, c_yu;
  logic [7:0] hr_v, dy_v, mo_v, last_dy;
  logic       fmt24, pm;

  // each digit rolls into the next; day and hour pairs need whole values
  always_comb begin
    for (int i = 0; i < `BCC_NDIG; i++) adv[i] = dig_q[i];
    hr_v = {2'b00, dig_q[`BCC_A_HR_T][1:0], dig_q[`BCC_A_HR_U]};
    dy_v = {2'b00, dig_q[`BCC_A_DAY_T][1:0], dig_q[`BCC_A_DAY_U]};
    mo_v = {3'b000, dig_q[`BCC_A_MON_T][0], dig_q[`BCC_A_MON_U]};
    fmt24 = dig_q[`BCC_A_HR_T][`BCC_HR_FMT_BIT];
    pm    = dig_q[`BCC_A_HR_T][`BCC_HR_PM_BIT];
    c_su = 1'b0; c_st = 1'b0; c_mu = 1'b0; c_mt = 1'b0;
    c_hr = 1'b0; c_dy = 1'b0; c_mo = 1'b0; c_yu = 1'b0;
    if (tick_go | tst_su) {c_su, adv[`BCC_A_SEC_U]} = bcc_step(dig_q[`BCC_A_SEC_U], 4'h9);
    if (c_su) {c_st, adv[`BCC_A_SEC_T]} = bcc_step(dig_q[`BCC_A_SEC_T], 4'h5);
    if (c_st | adj_min) {c_mu, adv[`BCC_A_MIN_U]} = bcc_step(dig_q[`BCC_A_MIN_U], 4'h9);
    if (c_mu | tst_mt) {c_mt, adv[`BCC_A_MIN_T]} = bcc_step(dig_q[`BCC_A_MIN_T], 4'h5);
    // hours wrap by format, flags kept in the tens digit
    if (c_mt) begin
      if (fmt24 && hr_v == 8'h23) begin
        adv[`BCC_A_HR_U] = 4'h0; adv[`BCC_A_HR_T][1:0] = 2'b00; c_hr = 1'b1;
      end else if (!fmt24 && hr_v == 8'h12) begin
        adv[`BCC_A_HR_U] = 4'h1; adv[`BCC_A_HR_T][1:0] = 2'b00;
      end else if (!fmt24 && hr_v == 8'h11) begin
        adv[`BCC_A_HR_U] = 4'h2; adv[`BCC_A_HR_T][1:0] = 2'b01;
        adv[`BCC_A_HR_T][`BCC_HR_PM_BIT] = ~pm; c_hr = pm;
      end else if (dig_q[`BCC_A_HR_U] == 4'h9) begin
        adv[`BCC_A_HR_U] = 4'h0; adv[`BCC_A_HR_T][1:0] = dig_q[`BCC_A_HR_T][1:0] + 2'b01;
      end else begin
        adv[`BCC_A_HR_U] = dig_q[`BCC_A_HR_U] + 4'h1;
      end
    end
    // month length, leap flag picks the february end
    case (mo_v)
      8'h02:   last_dy = dig_q[`BCC_A_DAY_T][`BCC_LEAP_BIT] ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_dy = 8'h30;
      default: last_dy = 8'h31;
    endcase
    if (c_hr | tst_dy) begin
      adv[`BCC_A_WDAY] = (dig_q[`BCC_A_WDAY] >= 4'h6) ? 4'h0 : dig_q[`BCC_A_WDAY] + 4'h1;
      if (dy_v >= last_dy) begin
        adv[`BCC_A_DAY_U] = 4'h1; adv[`BCC_A_DAY_T][1:0] = 2'b00; c_dy = 1'b1;
      end else if (dig_q[`BCC_A_DAY_U] == 4'h9) begin
        adv[`BCC_A_DAY_U] = 4'h0; adv[`BCC_A_DAY_T][1:0] = dig_q[`BCC_A_DAY_T][1:0] + 2'b01;
      end else begin
        adv[`BCC_A_DAY_U] = dig_q[`BCC_A_DAY_U] + 4'h1;
      end
    end
    if (c_dy) begin
      if (mo_v >= 8'h12) begin
        adv[`BCC_A_MON_U] = 4'h1; adv[`BCC_A_MON_T] = 4'h0; c_mo = 1'b1;
      end else if (dig_q[`BCC_A_MON_U] == 4'h9) begin
        adv[`BCC_A_MON_U] = 4'h0; adv[`BCC_A_MON_T] = 4'h1;
      end else begin
        adv[`BCC_A_MON_U] = dig_q[`BCC_A_MON_U] + 4'h1;
      end
    end
    if (c_mo | tst_yu) {c_yu, adv[`BCC_A_YR_U]} = bcc_step(dig_q[`BCC_A_YR_U], 4'h9);
    if (c_yu) adv[`BCC_A_YR_T] = 4'(bcc_step(dig_q[`BCC_A_YR_T], 4'h9));
  end

  // ============================================================
  // digit store: write beats adjust beats counting
  localparam logic [3:0] MASK [`BCC_NDIG] = '{4'hf, 4'h7, 4'hf, 4'h7, 4'hf, 4'hf, 4'h7,
                                              4'hf, 4'h7, 4'hf, 4'h1, 4'hf, 4'hf};
  wire sec_wr = wr_eff & (addr == `BCC_A_SEC_U || addr == `BCC_A_SEC_T);

  genvar gi;
  for (gi = 0; gi < `BCC_NDIG; gi++) begin : g_dig
    wire hit = wr_eff & (addr == 4'(gi));
    wire sec = (gi < 2);
    assign dig_d[gi] = (sec && (sec_wr || adj_fire)) ? 4'h0 :
                       hit ? (pins.data & MASK[gi]) : adv[gi];
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) dig_q[gi] <= `BCC_RESET_DIGIT;
      else        dig_q[gi] <= dig_d[gi];
    end
  end

  // ============================================================
  // read port and reference outputs
  wire ref_sec = (pre_q < 15'(REF_TB));
  wire s00 = (dig_q[`BCC_A_SEC_U] == 4'h0) && (dig_q[`BCC_A_SEC_T] == 4'h0);
  wire m00 = (dig_q[`BCC_A_MIN_U] == 4'h0) && (dig_q[`BCC_A_MIN_T] == 4'h0);
  // 1024 hz is divider stage five; pulses are suppressed under hold
  wire [3:0] ref_v = {ref_sec & s00 & m00 & ~hold_eff, ref_sec & s00 & ~hold_eff,
                      ref_sec & ~hold_eff, pre_q[4]};
  wire [3:0] rd_v  = (addr == `BCC_A_REF) ? ref_v :
                     (addr < 4'(`BCC_NDIG)) ? dig_q[addr] : 4'h0;

  // one cycle behind the pins; outputs come from flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dout_q <= 4'h0; doe_q <= 4'h0;
    end else begin
      dout_q <= rd_v;
      doe_q  <= {4{rd_eff}};
    end
  end

  assign pins.dev_o  = dout_q;
  assign pins.dev_oe = doe_q;
endmodule // bcc_dev
`default_nettype wire

// file: dv/bcc_sva.sv
// pin-level assertions between the host end and the clock calendar core
`timescale 1ns/10ps
`default_nettype none
module bcc_sva #(
  parameter int HOLD_CYC = 4,
  parameter int SEC_CYC  = 65536
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // pins
  input wire logic       cs,
  input wire logic       hold,
  input wire logic       rd,
  input wire logic       wr,
  input wire logic [3:0] addr,
  input wire logic [3:0] dev_o,
  input wire logic [3:0] dev_oe,
  input wire logic [3:0] host_oe
);
  int hold_cnt_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ============================================================
  // helper: length of the present hold, a counter avoids long repeats
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      hold_cnt_q <= 0;
    else
      hold_cnt_q <= hold ? hold_cnt_q + 1 : 0;
  end
  // ============================================================
  // properties
  property p_rd_drive;
    (rd && cs) |=> dev_oe == 4'hf;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("bus not driven on read");
  property p_rd_release;
    !(rd && cs) |=> dev_oe == 4'h0;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("bus driven idle");
  property p_cs_off;
    !cs |=> dev_oe == 4'h0;
  endproperty
  a_cs_off: assert property (p_cs_off) else $error("bus driven while off");
  property p_wr_qual;
    wr |-> host_oe == 4'hf && !rd;
  endproperty
  a_wr_qual: assert property (p_wr_qual) else $error("write without data");
  property p_hold_setup;
    $rose(rd || wr) |-> hold && $past(hold, HOLD_CYC);
  endproperty
  a_hold_setup: assert property (p_hold_setup) else $error("strobe before settle");
  property p_hold_len;
    hold_cnt_q < SEC_CYC;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("hold too long");
  property p_unmapped;
    $past(rd && cs && (addr == 4'hd || addr == 4'he)) |-> dev_o == 4'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unused digit not zero");
  property p_ref_hold;
    $past(rd && cs && hold && addr == 4'hf) |-> dev_o[3:1] == 3'h0;
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("pulse during hold");
endmodule // bcc_sva
`default_nettype wire

// file: dv/tb.sv
// self-checking bench: host end and core joined by their pin bundle
`timescale 1ns/10ps
`default_nettype none
module tb import bcc_pkg::*;;
  localparam int CLK_HZ   = 65536;
  localparam int HOLD_CYC = 4;
  logic       clk, rst_b, req_valid, req_write, req_ready, rsp_valid, adj_in, test_in;
  bcc_digit_t req_addr, req_wdata, rsp_rdata, q;
  int         fail_count, samples_checked;
  // ============================================================
  // two ends and the checker; slow clock rate shortens the time base
  bcc_if bus ();
  bcc_host #(.HOLD_CYC(HOLD_CYC), .STROBE_CYC(4)) bcc_host_i (.clk(clk), .rst_b(rst_b),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .adj_in(adj_in), .test_in(test_in), .pins(bus));
  bcc_dev #(.CLK_HZ(CLK_HZ), .TB_HZ(32768)) bcc_dev_i (.clk(clk), .rst_b(rst_b), .pins(bus));
  bcc_sva #(.HOLD_CYC(HOLD_CYC), .SEC_CYC(CLK_HZ)) bcc_sva_i (.clk(clk), .rst_b(rst_b),
    .cs(bus.cs), .hold(bus.hold), .rd(bus.rd), .wr(bus.wr), .addr(bus.addr),
    .dev_o(bus.dev_o), .dev_oe(bus.dev_oe), .host_oe(bus.host_oe));
  // ============================================================
  // helpers; all driving happens 1 ns after a rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input bcc_digit_t got, input bcc_digit_t exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input bcc_digit_t a, input bcc_digit_t d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    chk({3'b000, req_ready}, 4'h1);
    req_write = w;
    req_addr  = a;
    req_wdata = d;
    req_valid = 1'b1;
    step(1);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    chk({3'b000, rsp_valid}, 4'h1);
    q = rsp_rdata;
  endtask
  task automatic wr(input bcc_digit_t a, input bcc_digit_t d);
    xfer(1'b1, a, d);
  endtask
  task automatic rchk(input bcc_digit_t a, input bcc_digit_t e);
    xfer(1'b0, a, 4'h0);
    chk(q, e);
  endtask
  // test pulses advance the seconds units, minute tens, day units or year units digit if the host last addressed it
  task automatic pulse(input int k);
    repeat (k) begin
      test_in = 1'b1;
      step(2);
      test_in = 1'b0;
      step(2);
    end
  endtask
  // ============================================================
  // scenarios
  task automatic t_rw();
    wr(4'h2, 4'h7);
    rchk(4'h2, 4'h7);
    wr(4'h5, 4'h9);
    rchk(4'h5, 4'h9);
    wr(4'h5, 4'h5);
    rchk(4'h5, 4'h5);
    $display("test rw done");
  endtask
  task automatic t_sec();
    wr(4'h0, 4'h9);
    rchk(4'h0, 4'h0);
    wr(4'h1, 4'h5);
    rchk(4'h1, 4'h0);
    $display("test sec done");
  endtask
  task automatic t_carry();
    wr(4'h5, 4'h9);
    wr(4'h4, 4'h2);
    wr(4'h2, 4'h9);
    wr(4'h3, 4'h5);
    pulse(1);
    rchk(4'h3, 4'h0);
    rchk(4'h4, 4'h3);
    rchk(4'h2, 4'h9);
    // twelve-hour mode: 11 am to 12 pm, then 12 pm to 01 pm
    wr(4'h5, 4'h1);
    wr(4'h4, 4'h1);
    wr(4'h3, 4'h5);
    pulse(1);
    rchk(4'h5, 4'h5);
    rchk(4'h4, 4'h2);
    wr(4'h3, 4'h5);
    pulse(1);
    rchk(4'h5, 4'h4);
    rchk(4'h4, 4'h1);
    $display("test carry done");
  endtask
  task automatic t_leap();
    for (int l = 0; l < 2; l++) begin
      wr(4'ha, 4'h0);
      wr(4'h9, 4'h2);
      wr(4'h8, l ? 4'h6 : 4'h2);
      wr(4'h7, 4'h8);
      pulse(1);
      rchk(4'h7, l ? 4'h9 : 4'h1);
      rchk(4'h9, l ? 4'h2 : 4'h3);
    end
    $display("test leap done");
  endtask
  // adjust is held well past its 2048-cycle threshold at this clock
  task automatic t_adj();
    wr(4'h0, 4'h0);
    pulse(31);
    rchk(4'h1, 4'h3);
    rchk(4'h0, 4'h1);
    adj_in = 1'b1;
    step(2200);
    adj_in = 1'b0;
    step(2);
    rchk(4'h0, 4'h0);
    rchk(4'h2, 4'h0);
    rchk(4'h3, 4'h1);
    $display("test adj done");
  endtask
  // 1024 hz square flips every 32 clocks at this clock rate, even under hold
  task automatic t_ref();
    bcc_digit_t r;
    rchk(4'hd, 4'h0);
    xfer(1'b0, 4'hf, 4'h0);
    chk(q & 4'he, 4'h0);
    r = q;
    step(22);
    xfer(1'b0, 4'hf, 4'h0);
    chk({3'b000, q[0]}, {3'b000, ~r[0]});
    $display("test ref done");
  endtask
  // divider was cleared by the adjust; next second falls 65536 clocks later
  task automatic t_tick();
    step(64000);
    rchk(4'h0, 4'h0);
    step(2000);
    rchk(4'h0, 4'h1);
    rchk(4'h1, 4'h0);
    $display("test tick done");
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ============================================================
  // clock, main sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 4'h0;
    req_wdata = 4'h0;
    adj_in = 1'b0;
    test_in = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    step(12);
    rst_b = 1'b1;
    step(2);
    t_rw();
    t_sec();
    t_carry();
    t_leap();
    t_adj();
    t_ref();
    t_tick();
    wrap_up();
  end
  // whole run is about 69000 cycles; reaching 90000 means a hang
  initial begin
    step(90000);
    fail_count++;
    wrap_up();
  end
endmodule // tb
`default_nettype wire
